//--- verilog/pmem_params.svh
// Constants for the program store and table read unit.
// Assumes the includer uses these for the CPU-side program memory logic.
`ifndef PMEM_PARAMS_SVH
`define PMEM_PARAMS_SVH

// =====================================================================
// Store geometry
`define PMEM_WORDS     2048
`define PMEM_ADDR_W    11
`define PMEM_WORD_W    15
`define PAGE_WORDS     256
`define LAST_PAGE      3'h7
`define PC_RESET_VEC   11'h000
`define TBH_RESET      7'h00

// =====================================================================
// Core register addresses
`define SFR_PC_LOW     8'h06
`define SFR_TPL        8'h07
`define SFR_TBH        8'h08
`define SFR_TPH        8'h09

// =====================================================================
// Serial programming frame
`define SER_HDR_BITS   5'd12
`define SER_DATA_BITS  5'd15

`endif

//--- verilog/pmem_pkg.sv
// Types for the program store and table read unit.
// Assumes pmem_params.svh is on the include path.
package pmem_pkg;

  // =====================================================================
  // State encodings
  typedef enum logic [1:0] {
    TBL_IDLE = 2'b01,
    TBL_READ = 2'b10
  } tbl_state_t;

  typedef enum logic [2:0] {
    SER_HDR   = 3'b001,
    SER_WDATA = 3'b010,
    SER_RDATA = 3'b100
  } ser_state_t;

  // =====================================================================
  // Whole module state
  typedef struct packed {
    logic [10:0] pc;
    logic [14:0] instr;
    logic        instr_valid;
    logic [7:0]  tpl;
    logic [2:0]  tph;
    logic [6:0]  tbh;
    tbl_state_t  tst;
    logic        last;
    logic [7:0]  dest;
    logic        dm_wr;
    logic [7:0]  dm_data;
    logic [7:0]  sfr_rdata;
    logic        sck_q;
    ser_state_t  sst;
    logic [4:0]  cnt;
    logic        cmd;
    logic [10:0] saddr;
    logic [14:0] sdata;
    logic        sout;
    logic        soe;
    logic        wr_en;
  } state_t;

endpackage

//--- verilog/program_memory_table_read.sv
// Program store with instruction fetch, table reads and serial loading.
// Assumes the core issues one request per cycle on mclk, inputs are
// synchronous to mclk, and the serial clock is much slower than mclk.
`timescale 1ns/1ps
`include "pmem_params.svh"

module program_memory_table_read
  import pmem_pkg::*;
#(
  parameter int DEPTH = `PMEM_WORDS
) (
  input  wire logic        mclk,
  input  wire logic        rstn,
  input  wire logic        fetch_en,
  input  wire logic        pc_load,
  input  wire logic [10:0] pc_load_addr,
  output      logic [10:0] pc,
  output      logic [14:0] instr,
  output      logic        instr_valid,
  output      logic        fetch_stall,
  input  wire logic        tbl_start,
  input  wire logic        tbl_last_page,
  input  wire logic [7:0]  tbl_dest,
  output      logic        tbl_busy,
  output      logic        dm_wr,
  output      logic [7:0]  dm_addr,
  output      logic [7:0]  dm_wdata,
  input  wire logic        sfr_wr,
  input  wire logic [7:0]  sfr_addr,
  input  wire logic [7:0]  sfr_wdata,
  output      logic [7:0]  sfr_rdata,
  output      logic [7:0]  table_high_byte,
  input  wire logic        prog_mode,
  input  wire logic        debug_active,
  input  wire logic        prog_serial_clock,
  input  wire logic        prog_serial_data_i,
  output      logic        prog_serial_data_o,
  output      logic        prog_serial_data_oe,
  output      logic        pin_share_en
);

  // =====================================================================
  // Storage and state
  logic [14:0] mem [DEPTH];
  state_t      s_r;
  state_t      s_nxt;
  logic [10:0] tbl_addr;
  logic [10:0] rd_addr;
  logic [14:0] rd_word;
  logic [10:0] ser_addr;
  logic [14:0] ser_word;
  logic        sck_rise;
  logic        in_tbl;
  logic        pcl_wr;
  logic        hdr_last;
  logic        dat_last;

  // =====================================================================
  // Address helpers
  function automatic logic [10:0] page_addr(
    input logic [2:0] page,
    input logic [7:0] low
  );
    page_addr = {page, low};
  endfunction

  function automatic logic table_cycle(input tbl_state_t st);
    table_cycle = (st == TBL_READ);
  endfunction

  function automatic logic reg_write(
    input logic       wr,
    input logic [7:0] addr,
    input logic [7:0] want
  );
    reg_write = wr && (addr == want);
  endfunction

  function automatic logic frame_last(
    input logic [4:0] cnt,
    input logic [4:0] bits
  );
    frame_last = (cnt == (bits - 5'd1));
  endfunction

  // Bit 7 of the high byte has no store bit behind it and reads 0.
  function automatic logic [7:0] pad_high(input logic [6:0] v);
    pad_high = {1'b0, v};
  endfunction

  assign tbl_addr = s_r.last
                  ? page_addr(`LAST_PAGE, s_r.tpl)
                  : page_addr(s_r.tph, s_r.tpl);

  // The fetch read port of the store is lent to the table read in its second cycle.
  assign rd_addr  = in_tbl ? tbl_addr : s_r.pc;
  assign rd_word  = mem[rd_addr];
  assign ser_addr = {s_r.saddr[9:0], prog_serial_data_i};
  assign ser_word = mem[ser_addr];

  // =====================================================================
  // Decoded strobes
  // The serial clock rise is found against the previous mclk sample, so
  // every bit costs one mclk of lag; the clock must stay slow.
  assign in_tbl   = table_cycle(s_r.tst);
  assign pcl_wr   = reg_write(sfr_wr, sfr_addr, `SFR_PC_LOW);
  assign hdr_last = frame_last(s_r.cnt, `SER_HDR_BITS);
  assign dat_last = frame_last(s_r.cnt, `SER_DATA_BITS);
  assign sck_rise = prog_serial_clock & ~s_r.sck_q;

  // =====================================================================
  // Next state
  always_comb begin
    // Strobes last one cycle; every other field holds unless set below.
    s_nxt       = s_r;
    s_nxt.dm_wr = 1'b0;
    s_nxt.wr_en = 1'b0;
    s_nxt.sck_q = prog_serial_clock;

    // Pointer writes; a write to the high byte address is dropped.
    if (sfr_wr) begin
      case (sfr_addr)
        `SFR_TPL: begin
          s_nxt.tpl = sfr_wdata;
        end
        `SFR_TPH: begin
          s_nxt.tph = sfr_wdata[2:0];
        end
        `SFR_TBH: begin
          s_nxt.tbh = s_r.tbh;
        end
        default: begin
          s_nxt.tph = s_r.tph;
        end
      endcase
    end

    // Table read: request cycle, then store cycle.
    case (s_r.tst)
      TBL_IDLE: begin
        if (tbl_start) begin
          s_nxt.tst  = TBL_READ;
          s_nxt.last = tbl_last_page;
          s_nxt.dest = tbl_dest;
        end
      end
      TBL_READ: begin
        s_nxt.tst     = TBL_IDLE;
        s_nxt.dm_wr   = 1'b1;
        s_nxt.dm_data = rd_word[7:0];
        s_nxt.tbh     = rd_word[14:8];
      end
      default: begin
        s_nxt.tst = TBL_IDLE;
      end
    endcase

    // Fetch runs from the PC unless the table read owns the port.
    // A refused fetch leaves the PC alone; the core simply asks again.
    if (in_tbl) begin
      s_nxt.instr_valid = 1'b0;
    end else if (fetch_en) begin
      s_nxt.instr       = rd_word;
      s_nxt.instr_valid = 1'b1;
      s_nxt.pc          = s_r.pc + 11'd1;
    end else begin
      s_nxt.instr_valid = 1'b0;
    end

    // A jump beats a low-byte write, which beats the increment.
    if (pc_load) begin
      s_nxt.pc = pc_load_addr;
    end else if (pcl_wr) begin
      s_nxt.pc = page_addr(s_r.pc[10:8], sfr_wdata);
    end

    // Register read data lags the address by one cycle, so a pointer
    // written in one cycle reads back only from the cycle after.
    case (sfr_addr)
      `SFR_PC_LOW: begin
        s_nxt.sfr_rdata = s_r.pc[7:0];
      end
      `SFR_TPL: begin
        s_nxt.sfr_rdata = s_r.tpl;
      end
      `SFR_TBH: begin
        s_nxt.sfr_rdata = pad_high(s_r.tbh);
      end
      `SFR_TPH: begin
        s_nxt.sfr_rdata = {5'h00, s_r.tph};
      end
      default: begin
        s_nxt.sfr_rdata = 8'h00;
      end
    endcase

    // Serial loader: header of command and address, then a data word.
    if (!prog_mode) begin
      s_nxt.sst = SER_HDR;
      s_nxt.cnt = 5'd0;
      s_nxt.soe = 1'b0;
    end else if (sck_rise) begin
      case (s_r.sst)
        SER_HDR: begin
          s_nxt.cmd   = s_r.saddr[10];
          s_nxt.saddr = ser_addr;
          s_nxt.cnt   = s_r.cnt + 5'd1;
          if (hdr_last) begin
            s_nxt.cnt = 5'd0;
            if (s_r.saddr[10]) begin
              s_nxt.sst = SER_WDATA;
            end else begin
              s_nxt.sst   = SER_RDATA;
              s_nxt.sdata = ser_word;
              s_nxt.sout  = ser_word[14];
              s_nxt.soe   = 1'b1;
            end
          end
        end
        SER_WDATA: begin
          s_nxt.sdata = {s_r.sdata[13:0], prog_serial_data_i};
          s_nxt.cnt   = s_r.cnt + 5'd1;
          if (dat_last) begin
            s_nxt.cnt   = 5'd0;
            s_nxt.sst   = SER_HDR;
            s_nxt.wr_en = 1'b1;
          end
        end
        SER_RDATA: begin
          s_nxt.cnt = s_r.cnt + 5'd1;
          if (dat_last) begin
            s_nxt.cnt = 5'd0;
            s_nxt.sst = SER_HDR;
            s_nxt.soe = 1'b0;
          end else begin
            s_nxt.sdata = {s_r.sdata[13:0], 1'b0};
            s_nxt.sout  = s_r.sdata[13];
          end
        end
        default: begin
          s_nxt.sst = SER_HDR;
          s_nxt.cnt = 5'd0;
          s_nxt.soe = 1'b0;
        end
      endcase
    end
  end

  // =====================================================================
  // State register
  // Reset values are spelled out field by field, so a new field gets
  // no reset value until a line for it is added here.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      s_r.pc          <= `PC_RESET_VEC;
      s_r.instr       <= 15'h0000;
      s_r.instr_valid <= 1'b0;
      s_r.tpl         <= 8'h00;
      s_r.tph         <= 3'h0;
      s_r.tbh         <= `TBH_RESET;
      s_r.tst         <= TBL_IDLE;
      s_r.last        <= 1'b0;
      s_r.dest        <= 8'h00;
      s_r.dm_wr       <= 1'b0;
      s_r.dm_data     <= 8'h00;
      s_r.sfr_rdata   <= 8'h00;
      s_r.sck_q       <= 1'b0;
      s_r.sst         <= SER_HDR;
      s_r.cnt         <= 5'd0;
      s_r.cmd         <= 1'b0;
      s_r.saddr       <= 11'h000;
      s_r.sdata       <= 15'h0000;
      s_r.sout        <= 1'b0;
      s_r.soe         <= 1'b0;
      s_r.wr_en       <= 1'b0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // =====================================================================
  // Store write port
  // The store has no reset; its contents survive a device reset.
  always_ff @(posedge mclk) begin
    if (s_r.wr_en) begin
      mem[s_r.saddr] <= s_r.sdata;
    end
  end

  // =====================================================================
  // Outputs
  // Handshake outputs decode the state register; data outputs are flops.
  assign pc                  = s_r.pc;
  assign instr               = s_r.instr;
  assign instr_valid         = s_r.instr_valid;
  assign fetch_stall         = in_tbl;
  assign tbl_busy            = in_tbl;
  assign dm_wr               = s_r.dm_wr;
  assign dm_addr             = s_r.dest;
  assign dm_wdata            = s_r.dm_data;
  assign sfr_rdata           = s_r.sfr_rdata;
  assign table_high_byte     = pad_high(s_r.tbh);
  assign prog_serial_data_o  = s_r.sout;
  assign prog_serial_data_oe = s_r.soe;
  // Shared pin functions give way while a tool owns the two pins.
  assign pin_share_en        = ~(prog_mode | debug_active);

endmodule

//--- dv/program_memory_table_read_asserts.sv
// Checker for the program store and table read unit, on its ports.
// Assumes it is bound to program_memory_table_read, one clock domain.
`timescale 1ns/1ps
module program_memory_table_read_asserts (
  input wire logic        mclk,
  input wire logic        rstn,
  input wire logic        fetch_en,
  input wire logic        pc_load,
  input wire logic        sfr_wr,
  input wire logic [10:0] pc,
  input wire logic        instr_valid,
  input wire logic        fetch_stall,
  input wire logic        tbl_start,
  input wire logic        tbl_busy,
  input wire logic        dm_wr,
  input wire logic [7:0]  table_high_byte,
  input wire logic        prog_mode,
  input wire logic        debug_active,
  input wire logic        pin_share_en
);
  // ===================================================================
  // Properties
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  sequence s_tbl_run;
    tbl_busy ##1 (dm_wr && !tbl_busy);
  endsequence
  property p_tbl_two;
    tbl_start && !tbl_busy |=> s_tbl_run;
  endproperty
  a_tbl_two: assert property (p_tbl_two)
    else $error("table read length wrong");
  property p_wr_cause;
    dm_wr |-> $past(tbl_busy);
  endproperty
  a_wr_cause: assert property (p_wr_cause)
    else $error("data write without table read");
  property p_stall;
    tbl_busy == fetch_stall;
  endproperty
  a_stall: assert property (p_stall)
    else $error("stall and busy differ");
  property p_no_fetch;
    fetch_stall |=> !instr_valid;
  endproperty
  a_no_fetch: assert property (p_no_fetch)
    else $error("fetch taken during stall");
  property p_fetch;
    fetch_en && !fetch_stall && !pc_load && !sfr_wr
      |=> instr_valid && pc == $past(pc) + 11'h001;
  endproperty
  a_fetch: assert property (p_fetch)
    else $error("fetch did not advance");
  property p_thb_top;
    table_high_byte[7] == 1'b0;
  endproperty
  a_thb_top: assert property (p_thb_top)
    else $error("unused high bit set");
  property p_thb_ro;
    $changed(table_high_byte) |-> dm_wr;
  endproperty
  a_thb_ro: assert property (p_thb_ro)
    else $error("high byte changed outside read");
  property p_share;
    pin_share_en == !(prog_mode || debug_active);
  endproperty
  a_share: assert property (p_share)
    else $error("shared pin function wrong");
  property p_rst;
    $rose(rstn) |-> pc == 11'h000 && table_high_byte == 8'h00;
  endproperty
  a_rst: assert property (p_rst)
    else $error("reset state wrong");
endmodule

bind program_memory_table_read program_memory_table_read_asserts chk_i (
  .mclk(mclk), .rstn(rstn), .fetch_en(fetch_en), .pc_load(pc_load),
  .sfr_wr(sfr_wr), .pc(pc), .instr_valid(instr_valid),
  .fetch_stall(fetch_stall), .tbl_start(tbl_start), .tbl_busy(tbl_busy),
  .dm_wr(dm_wr), .table_high_byte(table_high_byte),
  .prog_mode(prog_mode), .debug_active(debug_active),
  .pin_share_en(pin_share_en));

//--- dv/core_model.sv
// Fetch side of the core pipeline, standing in for the execute logic.
// Assumes run only changes at rising edges, away from the falling one.
`timescale 1ns/1ps
module core_model (
  input  wire logic mclk,
  input  wire logic run,
  input  wire logic instr_valid,
  output      logic fetch_en,
  output      int   n_instr
);
  initial fetch_en = 1'b0;
  initial n_instr = 0;
  // Requests move at the falling edge so the block samples them clean.
  always @(negedge mclk) fetch_en <= run;
  always @(posedge mclk) if (instr_valid) n_instr <= n_instr + 1;
endmodule

//--- dv/tb_program_memory_table_read.sv
// Self-checking bench for the program store and table read unit.
// Assumes core_model and the bound checker are compiled alongside.
`timescale 1ns/1ps
module tb_program_memory_table_read;
  logic mclk = 1'b0, rstn = 1'b0, run = 1'b0, pc_load = 1'b0;
  logic tbl_start = 1'b0, tbl_last_page = 1'b0, sfr_wr = 1'b0;
  logic prog_mode = 1'b0, debug_active = 1'b0, sck = 1'b0, sd = 1'b0;
  logic [10:0] pc_load_addr = 11'h000, pc;
  logic [7:0]  tbl_dest = 8'h00, sfr_addr = 8'h00, sfr_wdata = 8'h00;
  logic [7:0]  dm_addr, dm_wdata, sfr_rdata, table_high_byte;
  logic [14:0] instr, rd;
  logic        fetch_en, instr_valid, fetch_stall, tbl_busy, dm_wr;
  logic        sdo, sdoe, pin_share_en;
  int          n_mismatch = 0, cmp_count = 0, n_instr;
  // The data pin follows the device whenever it drives.
  wire pin = sdoe ? sdo : sd;
  always #50 mclk = ~mclk;

  program_memory_table_read program_memory_table_read_i (
    .mclk(mclk), .rstn(rstn), .fetch_en(fetch_en), .pc_load(pc_load),
    .pc_load_addr(pc_load_addr), .pc(pc), .instr(instr),
    .instr_valid(instr_valid), .fetch_stall(fetch_stall),
    .tbl_start(tbl_start), .tbl_last_page(tbl_last_page),
    .tbl_dest(tbl_dest), .tbl_busy(tbl_busy), .dm_wr(dm_wr),
    .dm_addr(dm_addr), .dm_wdata(dm_wdata), .sfr_wr(sfr_wr),
    .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .table_high_byte(table_high_byte), .prog_mode(prog_mode),
    .debug_active(debug_active), .prog_serial_clock(sck),
    .prog_serial_data_i(pin), .prog_serial_data_o(sdo),
    .prog_serial_data_oe(sdoe), .pin_share_en(pin_share_en));
  core_model core_model_i (.mclk(mclk), .run(run),
    .instr_valid(instr_valid), .fetch_en(fetch_en), .n_instr(n_instr));

  // ===================================================================
  // Shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop;
    if (n_mismatch == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // One frame: command, address, data; the clock halves span 3 cycles.
  task automatic ser(input logic [26:0] f, output logic oe_all);
    oe_all = 1'b1;
    rd = 15'h0000;
    for (int i = 26; i >= 0; i--) begin
      sd = f[i];
      repeat (3) @(negedge mclk);
      sck = 1'b1;
      repeat (3) @(negedge mclk);
      sck = 1'b0;
      if (i <= 15 && i >= 1) begin
        rd = {rd[13:0], pin};
        oe_all &= sdoe;
      end
    end
    repeat (4) @(negedge mclk);
  endtask
  task automatic sfr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    sfr_wr = 1'b1;
    sfr_addr = a;
    sfr_wdata = d;
    @(negedge mclk);
    sfr_wr = 1'b0;
  endtask
  task automatic tbl(input logic l, input logic [7:0] dst,
                     input logic [14:0] w);
    @(negedge mclk);
    tbl_start = 1'b1;
    tbl_last_page = l;
    tbl_dest = dst;
    @(negedge mclk);
    tbl_start = 1'b0;
    chk({fetch_stall, tbl_busy}, 2'b11);
    @(negedge mclk);
    chk({dm_wr, dm_addr, dm_wdata}, {1'b1, dst, w[7:0]});
    chk(table_high_byte, {1'b0, w[14:8]});
  endtask
  task automatic fetch1;
    @(posedge mclk);
    run = 1'b1;
    @(posedge mclk);
    run = 1'b0;
    @(negedge mclk);
  endtask

  // ===================================================================
  // Scenarios
  task automatic t_load;
    logic oe;
    prog_mode = 1'b1;
    ser({1'b1, 11'h000, 15'h5a3c}, oe);
    ser({1'b1, 11'h2a5, 15'h7e81}, oe);
    ser({1'b1, 11'h705, 15'h0d1a}, oe);
    ser({1'b0, 11'h2a5, 15'h0000}, oe);
    chk({oe, rd}, {1'b1, 15'h7e81});
    chk(pin_share_en, 1'b0);
    prog_mode = 1'b0;
  endtask
  task automatic t_table;
    sfr(8'h07, 8'ha5);
    sfr(8'h09, 8'hfa);
    @(negedge mclk);
    chk(sfr_rdata, 8'h02);
    tbl(1'b0, 8'h40, 15'h7e81);
    sfr(8'h07, 8'h05);
    tbl(1'b1, 8'h41, 15'h0d1a);
    sfr(8'h08, 8'hff);
    chk(table_high_byte, 8'h0d);
  endtask
  task automatic t_fetch;
    sfr(8'h06, 8'h33);
    @(negedge mclk);
    rstn = 1'b0;
    @(negedge mclk);
    rstn = 1'b1;
    chk({pc, table_high_byte}, 19'h0);
    fetch1();
    chk({instr_valid, instr, pc}, {1'b1, 15'h5a3c, 11'h001});
    pc_load = 1'b1;
    pc_load_addr = 11'h2a5;
    @(negedge mclk);
    pc_load = 1'b0;
    fetch1();
    chk({instr, pc}, {15'h7e81, 11'h2a6});
    sfr(8'h06, 8'h05);
    @(negedge mclk);
    chk({pc, sfr_rdata}, {11'h205, 8'h05});
    chk(n_instr, 2);
    debug_active = 1'b1;
    @(negedge mclk);
    chk(pin_share_en, 1'b0);
    debug_active = 1'b0;
  endtask

  initial begin
    repeat (20) @(negedge mclk);
    rstn = 1'b1;
    chk({pc, table_high_byte}, 19'h0);
    t_load();
    t_table();
    t_fetch();
    report_and_stop();
  end
  initial begin
    repeat (20000) @(posedge mclk);
    n_mismatch++;
    report_and_stop();
  end
endmodule
